// File: logic/tlu_cmd_core.sv
/*
  Load/unload command sequencer and product data page server of a tape target.
  Assumes the initiator interface hands over a whole command block with a pulse,
  and the transport and write buffer report completion with one-cycle pulses.
*/
// Function
// RULE_01 - supported page byte 0 is 01h
// RULE_02 - supported page byte 1 is 00h
// RULE_03 - supported page length byte is 02h
// RULE_04 - supported list holds 00h then 80h
// RULE_05 - serial page byte 0 01h, 7Fh bad unit
// RULE_06 - serial page byte 1 is 80h
// RULE_07 - serial page length byte is 0Ah
// RULE_08 - ten serial characters, blank padded at end
// RULE_09 - opcode 1Bh is load/unload, fields decoded
// RULE_10 - load threads then goes to logical start
// RULE_11 - unload flushes, rewinds, unthreads, ejects in order
// RULE_12 - discard data left by failed write
// RULE_13 - early flag picks status before or after
// RULE_14 - disconnect if allowed, flush, then reconnect
// RULE_15 - flush may last up to 12 seconds
// RULE_16 - failed flush gives check, skips operation
// RULE_17 - end-of-tape and retension bits ignored
// RULE_18 - byte 4 bit 0 selects load or unload
// RULE_19 - unload without cartridge opens door always
// RULE_20 - load without cartridge gives illegal request
// RULE_21 - load flushes, positions, no needless motion
// RULE_22 - prevented removal skips only the eject
// RULE_23 - select bit picks standard or page data
// RULE_24 - reserved page bytes read as zero
`timescale 1ns/1ps
module tlu_cmd_core
  import tlu_pkg::*;
#(
  parameter logic [31:0] FLUSH_LIMIT = 32'(FLUSH_LIMIT_CYC)
)
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic cmd_valid_i,
  input wire tlu_cdb_t cdb_i,
  input wire logic disc_allowed_i,
  input wire tlu_media_t media_i,
  input wire logic flush_done_i,
  input wire logic flush_err_i,
  input wire logic mech_done_i,
  input wire tlu_serial_t serial_i,
  input wire logic [3:0] serial_len_i,
  input wire logic data_rd_i,
  input wire logic [7:0] data_idx_i,
  output logic busy_o,
  output logic std_inquiry_o,
  output logic [7:0] data_byte_o,
  output tlu_status_t status_o,
  output logic disconnect_o,
  output logic reconnect_o,
  output logic flush_req_o,
  output logic discard_o,
  output logic mech_req_o,
  output tlu_mech_t mech_op_o
);

  typedef struct packed {
    tlu_state_t st;
    logic load;
    logic immed;
    logic status_sent;
    tlu_mech_t step;
    logic [7:0] page;
    logic lun_bad;
    logic busy;
    logic std_inq;
    logic [7:0] data_byte;
    tlu_status_t status;
    logic disconnect;
    logic reconnect;
    logic flush_req;
    logic discard;
    logic mech_req;
    tlu_mech_t mech_op;
  } tlu_core_t;

  tlu_core_t cur_ff;
  tlu_core_t nxt_cur;
  logic [7:0] rom_byte;
  logic flush_expired;
  logic is_load_cmd;
  logic is_inq_cmd;
  tlu_mech_t first_step;
  tlu_mech_t follow_step;

  tlu_vpd_rom u_rom (
    .page_i(cur_ff.page),
    .lun_bad_i(cur_ff.lun_bad),
    .idx_i(data_idx_i),
    .serial_i(serial_i),
    .serial_len_i(serial_len_i),
    .byte_o(rom_byte)
  );

  tlu_flush_timer #(
    .LIMIT(FLUSH_LIMIT)
  ) u_tmr (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .run_i(cur_ff.st == S_FLUSH),
    .expired_o(flush_expired)
  );

  // Next mechanism step; MECH_NONE as input means start, as result means finished
  function automatic tlu_mech_t step_after(input logic load, input tlu_mech_t cur,
                                           input tlu_media_t m);
    tlu_mech_t res;
    res = MECH_NONE;
    if (load) begin
      if (cur == MECH_NONE && !m.threaded) begin
        res = MECH_THREAD; // RULE_10
      end else if ((cur == MECH_NONE && !m.logical_tape_start) || cur == MECH_THREAD) begin
        res = MECH_TO_LOGICAL_TAPE_START; // RULE_21
      end
    end else begin
      unique case (cur)
        MECH_NONE: res = MECH_REWIND; // RULE_11
        MECH_REWIND: res = MECH_UNTHREAD; // RULE_11
        MECH_UNTHREAD: res = m.removal_prevent ? MECH_NONE : MECH_EJECT; // RULE_22
        default: res = MECH_NONE;
      endcase
    end
    return res;
  endfunction : step_after

  // Opcode decode; end-of-tape and retension bits are never looked at
  assign is_load_cmd = cdb_i[0] == OP_LOAD_UNLOAD; // RULE_09 RULE_17
  assign is_inq_cmd = cdb_i[0] == OP_INQUIRY;
  assign first_step = step_after(cur_ff.load, MECH_NONE, media_i);
  assign follow_step = step_after(cur_ff.load, cur_ff.step, media_i);

  always_comb begin
    nxt_cur = cur_ff;
    // Handshake outputs are one-cycle pulses
    nxt_cur.status.valid = 1'b0;
    nxt_cur.reconnect = 1'b0;
    nxt_cur.flush_req = 1'b0;
    nxt_cur.discard = 1'b0;
    nxt_cur.mech_req = 1'b0;
    // Page bytes are served whenever asked, one cycle after the request
    if (data_rd_i) begin
      nxt_cur.data_byte = rom_byte;
    end
    unique case (cur_ff.st)
      S_IDLE: begin
        // Commands arriving while busy are not taken
        if (cmd_valid_i && is_inq_cmd) begin
          nxt_cur.std_inq = !cdb_i[1][B1_PRODUCT_DATA_PAGE_SELECT]; // RULE_23
          nxt_cur.page = cdb_i[2];
          nxt_cur.lun_bad = cdb_i[1][B1_LUN_MSB:B1_LUN_LSB] != 3'h0; // RULE_05
          nxt_cur.status.valid = 1'b1;
          nxt_cur.status.code = ST_GOOD;
          nxt_cur.status.sense_key = SK_NONE;
          if (cdb_i[1][B1_PRODUCT_DATA_PAGE_SELECT] && cdb_i[2] != PAGE_SUPPORTED && cdb_i[2] != PAGE_SERIAL) begin
            nxt_cur.status.code = ST_CHECK;
            nxt_cur.status.sense_key = SK_ILLEGAL;
          end
        end else if (cmd_valid_i && is_load_cmd) begin
          nxt_cur.load = cdb_i[4][B4_LOAD]; // RULE_18
          nxt_cur.immed = cdb_i[1][B1_IMMED]; // RULE_09
          nxt_cur.status_sent = 1'b0;
          nxt_cur.busy = 1'b1;
          // Data stranded by a failed write never reaches tape
          if (media_i.buf_after_err) begin
            nxt_cur.discard = 1'b1; // RULE_12
            nxt_cur.st = S_DISCARD;
          end else begin
            nxt_cur.st = S_DECIDE;
          end
        end
      end
      S_DISCARD: begin
        nxt_cur.st = S_DECIDE;
      end
      S_DECIDE: begin
        if (!media_i.cart_in && !cur_ff.load) begin
          // Door opens regardless of removal prevention
          nxt_cur.step = MECH_OPEN_DOOR; // RULE_19
          nxt_cur.st = S_MECH_REQ;
        end else if (!media_i.cart_in) begin
          nxt_cur.status.valid = 1'b1; // RULE_20
          nxt_cur.status.code = ST_CHECK;
          nxt_cur.status.sense_key = SK_ILLEGAL;
          nxt_cur.busy = 1'b0;
          nxt_cur.st = S_IDLE;
        end else if (media_i.buf_has_data) begin
          // Leave the bus only when the initiator allowed it
          nxt_cur.disconnect = disc_allowed_i; // RULE_14
          nxt_cur.flush_req = 1'b1; // RULE_11 RULE_21
          nxt_cur.st = S_FLUSH;
        end else if (first_step == MECH_NONE) begin
          nxt_cur.status.valid = 1'b1; // RULE_21
          nxt_cur.status.code = ST_GOOD;
          nxt_cur.status.sense_key = SK_NONE;
          nxt_cur.busy = 1'b0;
          nxt_cur.st = S_IDLE;
        end else begin
          nxt_cur.step = first_step;
          nxt_cur.st = S_MECH_REQ;
          if (cur_ff.immed) begin
            nxt_cur.status.valid = 1'b1; // RULE_13
            nxt_cur.status.code = ST_GOOD;
            nxt_cur.status.sense_key = SK_NONE;
            nxt_cur.status_sent = 1'b1;
          end
        end
      end
      S_FLUSH: begin
        if ((flush_done_i && flush_err_i) || flush_expired) begin
          // Failed flush: come back, report, do nothing mechanical
          nxt_cur.status.valid = 1'b1; // RULE_16
          nxt_cur.status.code = ST_CHECK;
          nxt_cur.status.sense_key = SK_MEDIUM;
          nxt_cur.reconnect = cur_ff.disconnect; // RULE_16
          nxt_cur.disconnect = 1'b0;
          nxt_cur.busy = 1'b0;
          nxt_cur.st = S_IDLE;
        end else if (flush_done_i) begin
          // Flushing moved the tape, so the first step is never skipped here
          nxt_cur.step = first_step;
          nxt_cur.st = S_MECH_REQ;
          if (cur_ff.immed) begin
            nxt_cur.reconnect = cur_ff.disconnect; // RULE_14
            nxt_cur.disconnect = 1'b0;
            nxt_cur.status.valid = 1'b1; // RULE_13 RULE_14
            nxt_cur.status.code = ST_GOOD;
            nxt_cur.status.sense_key = SK_NONE;
            nxt_cur.status_sent = 1'b1;
          end
        end
      end
      S_MECH_REQ: begin
        nxt_cur.mech_req = 1'b1;
        nxt_cur.mech_op = cur_ff.step;
        nxt_cur.st = S_MECH_WAIT;
      end
      S_MECH_WAIT: begin
        if (mech_done_i && (follow_step == MECH_NONE || cur_ff.step == MECH_OPEN_DOOR)) begin
          nxt_cur.step = MECH_NONE;
          nxt_cur.busy = 1'b0;
          nxt_cur.st = S_IDLE;
          if (!cur_ff.status_sent) begin
            nxt_cur.status.valid = 1'b1; // RULE_13
            nxt_cur.status.code = ST_GOOD;
            nxt_cur.status.sense_key = SK_NONE;
            nxt_cur.reconnect = cur_ff.disconnect;
            nxt_cur.disconnect = 1'b0;
          end
        end else if (mech_done_i) begin
          nxt_cur.step = follow_step; // RULE_10 RULE_11
          nxt_cur.st = S_MECH_REQ;
        end
      end
      default: begin
        nxt_cur.st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // Every output is a field of the state register
  assign busy_o = cur_ff.busy;
  assign std_inquiry_o = cur_ff.std_inq;
  assign data_byte_o = cur_ff.data_byte;
  assign status_o = cur_ff.status;
  assign disconnect_o = cur_ff.disconnect;
  assign reconnect_o = cur_ff.reconnect;
  assign flush_req_o = cur_ff.flush_req;
  assign discard_o = cur_ff.discard;
  assign mech_req_o = cur_ff.mech_req;
  assign mech_op_o = cur_ff.mech_op;

  sequence seq_load_no_cart;
    cmd_valid_i && cur_ff.st == S_IDLE && is_load_cmd && cdb_i[4][B4_LOAD] && !media_i.buf_after_err;
  endsequence

  sequence seq_check_illegal;
    status_o.valid && status_o.code == ST_CHECK && status_o.sense_key == SK_ILLEGAL;
  endsequence

  a_supp_byte0: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // RULE_01
    data_rd_i && cur_ff.page == PAGE_SUPPORTED && data_idx_i == IDX_DEVTYPE |=> data_byte_o == DEV_TYPE_SEQ)
    else $error("supported page byte 0 wrong");

  a_supp_second_code: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // RULE_04
    data_rd_i && cur_ff.page == PAGE_SUPPORTED && data_idx_i == IDX_SECOND |=> data_byte_o == PAGE_SERIAL)
    else $error("second supported page code wrong");

  a_serial_bad_lun: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // RULE_05
    data_rd_i && cur_ff.page == PAGE_SERIAL && cur_ff.lun_bad && data_idx_i == IDX_DEVTYPE
    |=> data_byte_o == DEV_LUN_BAD)
    else $error("bad unit not flagged in serial page");

  a_serial_pad: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // RULE_08
    data_rd_i && cur_ff.page == PAGE_SERIAL && data_idx_i <= IDX_SER_LAST
    && data_idx_i >= IDX_SER_FIRST + {4'h0, serial_len_i} |=> data_byte_o == PAD_CHAR)
    else $error("serial padding wrong");

  a_rsvd_zero: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // RULE_24
    data_rd_i && data_idx_i == IDX_RSVD |=> data_byte_o == RSVD_BYTE)
    else $error("reserved byte not zero");

  a_load_no_cart: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // RULE_20
    seq_load_no_cart ##1 !media_i.cart_in |=> seq_check_illegal)
    else $error("load without cartridge not refused");

  a_no_eject_prev: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // RULE_22
    $rose(mech_req_o) && media_i.removal_prevent && $past(media_i.removal_prevent) |-> mech_op_o != MECH_EJECT)
    else $error("eject despite prevented removal");

  a_disc_flush: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // RULE_14
    $rose(disconnect_o) |-> flush_req_o && cur_ff.st == S_FLUSH)
    else $error("disconnect outside a flush");

  a_late_status: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // RULE_13
    cur_ff.st == S_MECH_WAIT && !cur_ff.immed && !mech_done_i |=> !status_o.valid)
    else $error("status before operation finished");

  a_flush_fail: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // RULE_16
    cur_ff.st == S_FLUSH && flush_done_i && flush_err_i
    |=> status_o.valid && status_o.code == ST_CHECK ##1 !mech_req_o [*2])
    else $error("failed flush not reported or operation run");

endmodule : tlu_cmd_core

// File: logic/tlu_flush_timer.sv
/*
  Watchdog for the write-buffer flush.
  Assumes run_i stays high for the whole flush and drops when it ends.
*/
`timescale 1ns/1ps
module tlu_flush_timer
  import tlu_pkg::*;
#(
  parameter logic [31:0] LIMIT = 32'(FLUSH_LIMIT_CYC)
)
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic run_i,
  output logic expired_o
);

  typedef struct packed {
    logic [31:0] cnt;
    logic expired;
  } tlu_tmr_t;

  tlu_tmr_t cur_ff;
  tlu_tmr_t nxt_cur;

  // Count while the flush runs; a flush that outlives the limit is treated as failed
  always_comb begin
    nxt_cur = cur_ff;
    if (!run_i) begin
      nxt_cur.cnt = 32'h0000_0000;
      nxt_cur.expired = 1'b0;
    end else if (cur_ff.cnt >= LIMIT - 32'h0000_0001) begin
      nxt_cur.expired = 1'b1; // RULE_15
    end else begin
      nxt_cur.cnt = cur_ff.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign expired_o = cur_ff.expired;

endmodule : tlu_flush_timer

// File: logic/tlu_pkg.sv
/*
  Shared constants and types for the tape load/unload and product data page logic.
  Assumes one 125 MHz clock and a six-byte command block handed over whole.
*/
package tlu_pkg;

  // Operation codes and page codes
  localparam logic [7:0] OP_LOAD_UNLOAD = 8'h1B;
  localparam logic [7:0] OP_INQUIRY = 8'h12;
  localparam logic [7:0] PAGE_SUPPORTED = 8'h00;
  localparam logic [7:0] PAGE_SERIAL = 8'h80;

  // Page contents
  localparam logic [7:0] DEV_TYPE_SEQ = 8'h01;
  localparam logic [7:0] DEV_LUN_BAD = 8'h7F;
  localparam logic [7:0] LEN_SUPPORTED = 8'h02;
  localparam logic [7:0] LEN_SERIAL = 8'h0A;
  localparam logic [7:0] PAD_CHAR = 8'h20;
  localparam logic [7:0] RSVD_BYTE = 8'h00;

  // Byte positions inside the pages
  localparam logic [7:0] IDX_DEVTYPE = 8'h00;
  localparam logic [7:0] IDX_PAGE = 8'h01;
  localparam logic [7:0] IDX_RSVD = 8'h02;
  localparam logic [7:0] IDX_LEN = 8'h03;
  localparam logic [7:0] IDX_FIRST = 8'h04;
  localparam logic [7:0] IDX_SECOND = 8'h05;
  localparam logic [7:0] IDX_SER_FIRST = 8'h04;
  localparam logic [7:0] IDX_SER_LAST = 8'h0D;
  localparam int SER_CHARS = 10;

  // Command block field positions
  localparam int CDB_BYTES = 6;
  localparam int B1_IMMED = 0;
  localparam int B1_PRODUCT_DATA_PAGE_SELECT = 0;
  localparam int B1_LUN_MSB = 7;
  localparam int B1_LUN_LSB = 5;
  localparam int B4_LOAD = 0;
  localparam int B4_RETEN = 1;
  localparam int B4_EOT = 2;

  // Status bytes and sense keys
  localparam logic [7:0] ST_GOOD = 8'h00;
  localparam logic [7:0] ST_CHECK = 8'h02;
  localparam logic [3:0] SK_NONE = 4'h0;
  localparam logic [3:0] SK_MEDIUM = 4'h3;
  localparam logic [3:0] SK_ILLEGAL = 4'h5;

  // Flush time limit
  localparam longint FLUSH_LIMIT_S = 12;
  localparam longint CLK_PERIOD_NS = 8;
  localparam longint FLUSH_LIMIT_CYC = FLUSH_LIMIT_S * 64'd1000000000 / CLK_PERIOD_NS;

  typedef logic [0:CDB_BYTES-1][7:0] tlu_cdb_t;
  typedef logic [0:SER_CHARS-1][7:0] tlu_serial_t;

  // Mechanism steps handed to the transport
  typedef enum logic [2:0] {
    MECH_NONE = 3'b000,
    MECH_THREAD = 3'b001,
    MECH_TO_LOGICAL_TAPE_START = 3'b010,
    MECH_REWIND = 3'b011,
    MECH_UNTHREAD = 3'b100,
    MECH_EJECT = 3'b101,
    MECH_OPEN_DOOR = 3'b110
  } tlu_mech_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_DISCARD = 3'b001,
    S_DECIDE = 3'b010,
    S_FLUSH = 3'b011,
    S_MECH_REQ = 3'b100,
    S_MECH_WAIT = 3'b101
  } tlu_state_t;

  // Cartridge and buffer condition seen by the command logic
  typedef struct packed {
    logic cart_in;
    logic threaded;
    logic logical_tape_start;
    logic buf_has_data;
    logic buf_after_err;
    logic removal_prevent;
  } tlu_media_t;

  // Status returned to the initiator
  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [3:0] sense_key;
  } tlu_status_t;

endpackage : tlu_pkg

// File: logic/tlu_vpd_rom.sv
/*
  Byte source for the supported-pages and serial number product data pages.
  Assumes the caller registers the byte; purely combinational here.
*/
`timescale 1ns/1ps
module tlu_vpd_rom
  import tlu_pkg::*;
(
  input wire logic [7:0] page_i,
  input wire logic lun_bad_i,
  input wire logic [7:0] idx_i,
  input wire tlu_serial_t serial_i,
  input wire logic [3:0] serial_len_i,
  output logic [7:0] byte_o
);

  logic [7:0] pos;

  // Serial characters count from the first serial byte
  assign pos = idx_i - IDX_SER_FIRST;

  // Fixed fields and serial characters first, everything else reads as zero
  always_comb begin
    byte_o = RSVD_BYTE; // RULE_24
    if (page_i == PAGE_SUPPORTED) begin
      unique case (idx_i)
        IDX_DEVTYPE: byte_o = DEV_TYPE_SEQ; // RULE_01
        IDX_PAGE: byte_o = PAGE_SUPPORTED; // RULE_02
        IDX_LEN: byte_o = LEN_SUPPORTED; // RULE_03
        IDX_FIRST: byte_o = PAGE_SUPPORTED; // RULE_04
        IDX_SECOND: byte_o = PAGE_SERIAL; // RULE_04
        default: byte_o = RSVD_BYTE;
      endcase
    end else if (page_i == PAGE_SERIAL) begin
      if (idx_i == IDX_DEVTYPE) begin
        byte_o = lun_bad_i ? DEV_LUN_BAD : DEV_TYPE_SEQ; // RULE_05
      end else if (idx_i == IDX_PAGE) begin
        byte_o = PAGE_SERIAL; // RULE_06
      end else if (idx_i == IDX_LEN) begin
        byte_o = LEN_SERIAL; // RULE_07
      end else if (idx_i >= IDX_SER_FIRST && idx_i <= IDX_SER_LAST) begin
        // Short serials are blank filled at the end
        byte_o = (pos < {4'h0, serial_len_i}) ? serial_i[pos[3:0]] : PAD_CHAR; // RULE_08
      end
    end
  end

endmodule : tlu_vpd_rom

// File: sim/tape_vpd_pages_and_load_unload_tb.sv
/*
  Self-checking bench for the load/unload sequencer and product data pages.
  Assumes the core and the far model above; flush watchdog shortened to 50 cycles.
*/
`timescale 1ns/1ps
module tape_vpd_pages_and_load_unload_tb
  import tlu_pkg::*;
;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic cmd_valid = 1'b0, disc = 1'b0, fail = 1'b0, slow = 1'b0, data_rd = 1'b0, clr = 1'b0;
  tlu_cdb_t cdb = '0;
  tlu_media_t media = '0;
  tlu_serial_t serial = 80'h4142434445464748494A;
  logic [3:0] ser_len = 4'h7;
  logic [7:0] data_idx = 8'h00;
  logic flush_done, flush_err, mech_done, busy_o, std_inquiry_o, disconnect_o, reconnect_o;
  logic flush_req_o, discard_o, mech_req_o;
  logic [7:0] data_byte_o;
  tlu_status_t status_o;
  tlu_mech_t mech_op_o;
  logic [11:0] ops = '0, st = '0;
  int n_mech = 0, st_n = 0, mech_pre = 0, n_disc = 0, failures = 0, cmp_count = 0;
  logic disc_seen = 1'b0, rec_st = 1'b0;
  localparam logic [7:0] SUP [0:5] = '{8'h01, 8'h00, 8'h00, 8'h02, 8'h00, 8'h80};
  localparam logic [7:0] SER [0:3] = '{8'h01, 8'h80, 8'h00, 8'h0A};

  always #4 core_clk_i = ~core_clk_i;

  tlu_cmd_core #(.FLUSH_LIMIT(32'd50)) DUT (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .cmd_valid_i(cmd_valid),
    .cdb_i(cdb), .disc_allowed_i(disc), .media_i(media), .flush_done_i(flush_done), .flush_err_i(flush_err),
    .mech_done_i(mech_done), .serial_i(serial), .serial_len_i(ser_len), .data_rd_i(data_rd), .data_idx_i(data_idx),
    .busy_o(busy_o), .std_inquiry_o(std_inquiry_o), .data_byte_o(data_byte_o), .status_o(status_o),
    .disconnect_o(disconnect_o), .reconnect_o(reconnect_o), .flush_req_o(flush_req_o), .discard_o(discard_o),
    .mech_req_o(mech_req_o), .mech_op_o(mech_op_o));

  tlu_far_model far (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .flush_req_i(flush_req_o), .mech_req_i(mech_req_o),
    .fail_i(fail), .slow_i(slow), .flush_done_o(flush_done), .flush_err_o(flush_err), .mech_done_o(mech_done));

  // Log of mechanism steps and status pulses for the current command; cleared as it is issued
  always @(posedge core_clk_i) begin
    if (mech_req_o) begin
      ops <= {ops[8:0], mech_op_o};
      n_mech <= n_mech + 1;
    end
    if (status_o.valid) begin
      st <= {status_o.code, status_o.sense_key};
      st_n <= st_n + 1;
      mech_pre <= n_mech;
      rec_st <= reconnect_o;
    end
    if (discard_o) n_disc <= n_disc + 1;
    if (disconnect_o) disc_seen <= 1'b1;
    if (clr) begin
      ops <= '0;
      n_mech <= 0;
      st_n <= 0;
      n_disc <= 0;
      disc_seen <= 1'b0;
      rec_st <= 1'b0;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Issue one command; x holds disconnect-allowed, flush failure and slow flush
  task automatic run(input tlu_cdb_t c, input logic [5:0] m, input logic [2:0] x, input logic ign);
    int i;
    int lim;
    lim = ign ? 10 : 3000;
    @(posedge core_clk_i);
    cdb <= c;
    media <= tlu_media_t'(m);
    {disc, fail, slow} <= x;
    cmd_valid <= 1'b1;
    clr <= 1'b1;
    @(posedge core_clk_i);
    cmd_valid <= 1'b0;
    clr <= 1'b0;
    // The log clears on this edge, so its counts are only trusted one edge later
    @(posedge core_clk_i);
    for (i = 0; i < lim && !(st_n > 0 && busy_o === 1'b0); i++) @(posedge core_clk_i);
    // Late pulses after the final status are still caught by the log
    repeat (3) @(posedge core_clk_i);
    if (i == lim && !ign) chk(16'h1, 16'h0, "command never completed");
  endtask : run

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    @(posedge core_clk_i);
    data_rd <= 1'b1;
    data_idx <= idx;
    @(posedge core_clk_i);
    data_rd <= 1'b0;
    data_idx <= ~idx;
    #1 chk(data_byte_o, exp, "page byte");
  endtask : rd

  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  // Hang guard well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (60000) @(posedge core_clk_i);
    failures++;
    tally_and_finish();
  end

  initial begin
    repeat (20) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    @(posedge core_clk_i);
    #1 chk({busy_o, status_o.valid, mech_req_o}, 16'h0, "reset outputs");
    run({OP_INQUIRY, 8'h01, 8'h00, 24'h000600}, 6'h00, 3'h0, 1'b0);
    chk(st, {ST_GOOD, SK_NONE}, "page 00 status");
    for (int i = 0; i < 6; i++) rd(8'(i), SUP[i]);
    run({OP_INQUIRY, 8'h01, 8'h80, 24'h000E00}, 6'h00, 3'h0, 1'b0);
    for (int i = 0; i < 4; i++) rd(8'(i), SER[i]);
    for (int i = 0; i < 10; i++) rd(8'(4 + i), (i < 7) ? 8'(8'h41 + i) : 8'h20);
    run({OP_INQUIRY, 8'h21, 8'h80, 24'h000E00}, 6'h00, 3'h0, 1'b0);
    // Full-length serial: the last character must not be padded
    ser_len <= 4'hA;
    rd(8'h00, 8'h7F);
    rd(8'h0D, 8'h4A);
    run({OP_INQUIRY, 8'h00, 8'h00, 24'h006A00}, 6'h00, 3'h0, 1'b0);
    chk(std_inquiry_o, 16'h1, "standard data select");
    run({OP_INQUIRY, 8'h01, 8'h55, 24'h000600}, 6'h00, 3'h0, 1'b0);
    chk(st, {ST_CHECK, SK_ILLEGAL}, "unknown page");
    // Load paths: no cartridge, unthreaded with ignored bits set, already in place, stale data
    run({OP_LOAD_UNLOAD, 8'h00, 16'h0000, 8'h01, 8'h00}, 6'h00, 3'h0, 1'b0);
    chk({st, 4'(n_mech)}, {ST_CHECK, SK_ILLEGAL, 4'h0}, "load without cartridge");
    run({OP_LOAD_UNLOAD, 8'h00, 16'h0000, 8'h07, 8'h00}, 6'h20, 3'h0, 1'b0);
    chk({st, ops}, {ST_GOOD, SK_NONE, 12'h00A}, "load steps");
    chk(16'(mech_pre), 16'h2, "status after load");
    run({OP_LOAD_UNLOAD, 8'h00, 16'h0000, 8'h01, 8'h00}, 6'h38, 3'h0, 1'b0);
    chk({st, 4'(n_mech)}, {ST_GOOD, SK_NONE, 4'h0}, "no needless motion");
    run({OP_LOAD_UNLOAD, 8'h00, 16'h0000, 8'h01, 8'h00}, 6'h3A, 3'h0, 1'b0);
    chk({4'(n_disc), 4'(n_mech)}, 16'h10, "discard stale data");
    // Unload paths: early status with flush, prevented removal, no cartridge
    run({OP_LOAD_UNLOAD, 8'h01, 16'h0000, 8'h00, 8'h00}, 6'h24, 3'h4, 1'b0);
    chk({st, ops}, {ST_GOOD, SK_NONE, 12'h0E5}, "unload steps");
    chk({4'(mech_pre), 4'(st_n), 3'h0, disc_seen, 3'h0, rec_st}, 16'h0111, "early status");
    run({OP_LOAD_UNLOAD, 8'h00, 16'h0000, 8'h00, 8'h00}, 6'h21, 3'h0, 1'b0);
    chk({4'(mech_pre), ops}, 16'h201C, "prevented unload");
    run({OP_LOAD_UNLOAD, 8'h00, 16'h0000, 8'h00, 8'h00}, 6'h01, 3'h0, 1'b0);
    chk({st, ops}, {ST_GOOD, SK_NONE, 12'h006}, "door opens");
    // Flush failure without disconnect, then a flush that outlasts the watchdog
    run({OP_LOAD_UNLOAD, 8'h01, 16'h0000, 8'h00, 8'h00}, 6'h24, 3'h2, 1'b0);
    chk({st, 3'h0, disc_seen}, {ST_CHECK, SK_MEDIUM, 4'h0}, "flush failure");
    chk(16'(n_mech), 16'h0, "no motion after failure");
    run({OP_LOAD_UNLOAD, 8'h00, 16'h0000, 8'h01, 8'h00}, 6'h3C, 3'h5, 1'b0);
    chk({st, 3'h0, rec_st}, {ST_CHECK, SK_MEDIUM, 4'h1}, "flush timeout");
    run({8'h00, 8'h00, 32'h00000000}, 6'h20, 3'h0, 1'b1);
    chk({4'(st_n), 3'h0, busy_o}, 16'h0, "other opcode ignored");
    tally_and_finish();
  end
endmodule : tape_vpd_pages_and_load_unload_tb

// File: sim/tlu_far_model.sv
/*
  Behavioural write buffer and tape transport facing the command core.
  Assumes one-cycle request pulses and answers each with a one-cycle done pulse.
*/
`timescale 1ns/1ps
module tlu_far_model
  import tlu_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic flush_req_i,
  input wire logic mech_req_i,
  input wire logic fail_i,
  input wire logic slow_i,
  output logic flush_done_o,
  output logic flush_err_o,
  output logic mech_done_o
);
  int fcnt;
  int mcnt;

  // Countdowns for a flush and a mechanism step; slow mode outlasts a short watchdog
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fcnt <= 0;
      mcnt <= 0;
      flush_done_o <= 1'b0;
      mech_done_o <= 1'b0;
    end else begin
      flush_done_o <= (fcnt == 1);
      mech_done_o <= (mcnt == 1);
      if (flush_req_i) fcnt <= slow_i ? 200 : 20;
      else if (fcnt > 0) fcnt <= fcnt - 1;
      if (mech_req_i) mcnt <= 4;
      else if (mcnt > 0) mcnt <= mcnt - 1;
    end
  end

  // Error level is only valid beside done; elsewhere it shows the opposite value
  assign flush_err_o = flush_done_o ? fail_i : ~fail_i;
endmodule : tlu_far_model
